// File: verilog/pim_mask_logic.sv
// interrupt status and mask registers with interrupt pin control
`timescale 1ns/1ns
`default_nettype none

// Function
// (RULE_01) Fault bit 5 is one while switch three is off for overheating.
// (RULE_02) Fault bit 4 is one while switch two is off for heat or low input.
// (RULE_03) Fault bit 3 is one while switch one is off for overheating.
// (RULE_04) Bits 2..0 are one while switches three..one limit current.
// (RULE_05) A zero mask bit lets its event pull the pin low; a one blocks it.
// (RULE_06) Masks gate only the pin; status and pending bits keep recording.
// (RULE_07) First mask 5..0: prog voltage, mains, button, hot, coin cell, nvm.
// (RULE_08) Second mask bits 5..3: switch faults; bits 2..0: current limits.
// (RULE_09) First mask at 0x3 resets to zero; bits 7..6 read zero.
// (RULE_10) Second mask at 0x4 resets to zero; bits 7..6 read zero.
// (RULE_11) Switch status is read-only at subaddress 0x2 and resets to zero.
// (RULE_12) Mains-detect and button events fire on any change of input level.
// (RULE_13) The pin is released high once no unmasked pending event remains.
module pim_mask_logic
    import pim_pkg::*;
(
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         srst,
    // register port
    input  wire pim_reg_req_s reg_req,
    output pim_reg_rsp_s      reg_rsp,
    // monitored conditions
    input  wire pim_sw_cond_s sw_cond,
    input  wire pim_evt_src_s evt_src,
    // interrupt pin toward the host
    output logic              irq_out_n
);

    typedef struct packed {
        logic [7:0]           event_mask_one;
        logic [7:0]           switch_event_mask;
        logic [7:0]           switch_event_status;
        logic [PIM_EVT_W-1:0] event_pending;
        pim_reg_rsp_s         rsp;
    } pim_state_s;

    pim_state_s st_q;
    pim_state_s st_d;

    logic mains_change;
    logic button_change;
    logic [PIM_EVT_W-1:0] evt_set;
    logic [PIM_EVT_W-1:0] sw_now;

    // address decode shared by read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    pim_chg_det u_mains_chg (
        .sys_clk (sys_clk),
        .srst    (srst),
        .level   (evt_src.mains_detect_in),
        .changed (mains_change)
    );

    pim_chg_det u_button_chg (
        .sys_clk (sys_clk),
        .srst    (srst),
        .level   (evt_src.button_in),
        .changed (button_change)
    );

    // live load-switch status
    always_comb begin
        sw_now = '0;
        sw_now[PIM_BIT_SW3_FAULT] = sw_cond.overtemp[3]; // RULE_01
        sw_now[PIM_BIT_SW2_FAULT] = sw_cond.overtemp[2]
                                  | sw_cond.sw2_undervolt; // RULE_02
        sw_now[PIM_BIT_SW1_FAULT] = sw_cond.overtemp[1]; // RULE_03
        sw_now[PIM_BIT_SW3_LIMIT] = sw_cond.limit_active[3]
                                  & sw_cond.enabled[3]; // RULE_04
        sw_now[PIM_BIT_SW2_LIMIT] = sw_cond.limit_active[2]
                                  & sw_cond.enabled[2]; // RULE_04
        sw_now[PIM_BIT_SW1_LIMIT] = sw_cond.limit_active[1]
                                  & sw_cond.enabled[1]; // RULE_04
    end

    // events behind the first mask register
    always_comb begin
        evt_set = '0;
        evt_set[PIM_BIT_PROG_VOLTAGE] = evt_src.prog_voltage_low; // RULE_07
        evt_set[PIM_BIT_MAINS]        = mains_change; // RULE_07 RULE_12
        evt_set[PIM_BIT_BUTTON]       = button_change; // RULE_07 RULE_12
        evt_set[PIM_BIT_OVERTEMP]     = evt_src.overtemp_warn; // RULE_07
        evt_set[PIM_BIT_COIN_CELL]    = evt_src.coin_cell_done; // RULE_07
        evt_set[PIM_BIT_NVM]          = evt_src.nvm_done; // RULE_07
    end

    always_comb begin
        st_d = st_q;
        // status follows the conditions whatever the masks hold
        st_d.switch_event_status = {2'b00, sw_now}; // RULE_06 RULE_11

        // reading the event register clears it; a new event wins
        if (reg_req.rd && hit(reg_req.addr, PIM_ADDR_EVENT_ONE)) begin
            st_d.event_pending = evt_set; // RULE_13
        end else begin
            st_d.event_pending = st_q.event_pending | evt_set; // RULE_06
        end

        if (reg_req.wr && hit(reg_req.addr, PIM_ADDR_MASK_ONE)) begin
            st_d.event_mask_one = reg_req.wdata & PIM_FIELD_BITS; // RULE_09
        end
        if (reg_req.wr && hit(reg_req.addr, PIM_ADDR_SW_MASK)) begin
            st_d.switch_event_mask = reg_req.wdata & PIM_FIELD_BITS; // RULE_10
        end

        st_d.rsp.rvalid = reg_req.rd;
        st_d.rsp.rdata  = PIM_READ_IDLE;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                PIM_ADDR_EVENT_ONE: begin
                    st_d.rsp.rdata = {2'b00, st_q.event_pending};
                end
                PIM_ADDR_SW_STATUS: begin
                    st_d.rsp.rdata = st_q.switch_event_status; // RULE_11
                end
                PIM_ADDR_MASK_ONE: begin
                    st_d.rsp.rdata = st_q.event_mask_one; // RULE_09
                end
                PIM_ADDR_SW_MASK: begin
                    st_d.rsp.rdata = st_q.switch_event_mask; // RULE_10
                end
                default: begin
                    st_d.rsp.rdata = PIM_READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q.event_mask_one      <= PIM_RST_MASK_ONE; // RULE_09
            st_q.switch_event_mask   <= PIM_RST_SW_MASK; // RULE_10
            st_q.switch_event_status <= PIM_RST_SW_STATUS; // RULE_11
            st_q.event_pending       <= PIM_RST_EVENT_ONE[PIM_EVT_W-1:0];
            st_q.rsp                 <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rsp = st_q.rsp;

    pim_irq_drv u_irq (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .evt_one   (st_q.event_pending),
        .mask_one  (st_q.event_mask_one[PIM_EVT_W-1:0]),
        .evt_sw    (st_q.switch_event_status[PIM_EVT_W-1:0]),
        .mask_sw   (st_q.switch_event_mask[PIM_EVT_W-1:0]), // RULE_08
        .irq_out_n (irq_out_n)
    );

endmodule : pim_mask_logic
`default_nettype wire

// File: verilog/pim_pkg.sv
// constants and carrier types of the interrupt status and mask block
package pim_pkg;

    // register subaddresses
    localparam logic [7:0] PIM_ADDR_EVENT_ONE  = 8'h01;
    localparam logic [7:0] PIM_ADDR_SW_STATUS  = 8'h02;
    localparam logic [7:0] PIM_ADDR_MASK_ONE   = 8'h03;
    localparam logic [7:0] PIM_ADDR_SW_MASK    = 8'h04;

    // reset values and implemented bits
    localparam logic [7:0] PIM_RST_MASK_ONE    = 8'h00;
    localparam logic [7:0] PIM_RST_SW_MASK     = 8'h00;
    localparam logic [7:0] PIM_RST_SW_STATUS   = 8'h00;
    localparam logic [7:0] PIM_RST_EVENT_ONE   = 8'h00;
    localparam logic [7:0] PIM_FIELD_BITS      = 8'h3F;
    localparam logic [7:0] PIM_READ_IDLE       = 8'h00;

    localparam int PIM_EVT_W = 6;

    // field positions, first mask register and its events
    localparam int PIM_BIT_PROG_VOLTAGE = 5;
    localparam int PIM_BIT_MAINS        = 4;
    localparam int PIM_BIT_BUTTON       = 3;
    localparam int PIM_BIT_OVERTEMP     = 2;
    localparam int PIM_BIT_COIN_CELL    = 1;
    localparam int PIM_BIT_NVM          = 0;

    // field positions, switch status and switch mask registers
    localparam int PIM_BIT_SW3_FAULT    = 5;
    localparam int PIM_BIT_SW2_FAULT    = 4;
    localparam int PIM_BIT_SW1_FAULT    = 3;
    localparam int PIM_BIT_SW3_LIMIT    = 2;
    localparam int PIM_BIT_SW2_LIMIT    = 1;
    localparam int PIM_BIT_SW1_LIMIT    = 0;

    // register port request and answer
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pim_reg_req_s;

    typedef struct packed {
        logic       rvalid;
        logic [7:0] rdata;
    } pim_reg_rsp_s;

    // raw load-switch conditions from the analog side
    typedef struct packed {
        logic [3:1] overtemp;
        logic       sw2_undervolt;
        logic [3:1] limit_active;
        logic [3:1] enabled;
    } pim_sw_cond_s;

    // raw conditions behind the first mask register
    typedef struct packed {
        logic prog_voltage_low;
        logic mains_detect_in;
        logic button_in;
        logic overtemp_warn;
        logic coin_cell_done;
        logic nvm_done;
    } pim_evt_src_s;

endpackage : pim_pkg

// File: verilog/pim_chg_det.sv
// change detector: one-cycle pulse on either edge of a level
`timescale 1ns/1ns
`default_nettype none
module pim_chg_det
    import pim_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic srst,
    // level and change pulse
    input  wire logic level,
    output logic      changed
);

    typedef struct packed {
        logic prev;
        logic armed;
    } pim_chg_state_s;

    pim_chg_state_s st_q;
    pim_chg_state_s st_d;

    // no pulse before the first sample is held
    assign changed = st_q.armed & (level ^ st_q.prev); // RULE_12

    always_comb begin
        st_d       = st_q;
        st_d.prev  = level;
        st_d.armed = 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule : pim_chg_det
`default_nettype wire

// File: verilog/pim_irq_drv.sv
// active-low interrupt driver from pending events and masks
`timescale 1ns/1ns
`default_nettype none
module pim_irq_drv
    import pim_pkg::*;
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 srst,
    // pending events and their masks
    input  wire logic [PIM_EVT_W-1:0] evt_one,
    input  wire logic [PIM_EVT_W-1:0] mask_one,
    input  wire logic [PIM_EVT_W-1:0] evt_sw,
    input  wire logic [PIM_EVT_W-1:0] mask_sw,
    // interrupt pin
    output logic                      irq_out_n
);

    typedef struct packed {
        logic irq_n;
    } pim_irq_state_s;

    pim_irq_state_s st_q;
    pim_irq_state_s st_d;

    always_comb begin
        st_d = st_q;
        // a set mask bit removes its event from the pin only
        st_d.irq_n = ~(|(evt_one & ~mask_one)
                     | |(evt_sw & ~mask_sw)); // RULE_05 RULE_13
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_q <= '{irq_n: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    assign irq_out_n = st_q.irq_n;

endmodule : pim_irq_drv
`default_nettype wire

// File: testbench/pim_mask_logic_monitor.sv
// checker of register answers and interrupt pin behaviour
`timescale 1ns/1ns
`default_nettype none
module pim_mask_logic_monitor
    import pim_pkg::*;
(
    // watched ports of the block
    input wire logic         sys_clk,
    input wire logic         srst,
    input wire pim_reg_req_s reg_req,
    input wire pim_reg_rsp_s reg_rsp,
    input wire pim_sw_cond_s sw_cond,
    input wire pim_evt_src_s evt_src,
    input wire logic         irq_out_n
);
    logic [5:0] m1_q;
    logic [5:0] m2_q;

    // shadow copies of the two mask registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            m1_q <= 6'h00;
            m2_q <= 6'h00;
        end else if (reg_req.wr && reg_req.addr == PIM_ADDR_MASK_ONE) begin
            m1_q <= reg_req.wdata[5:0];
        end else if (reg_req.wr && reg_req.addr == PIM_ADDR_SW_MASK) begin
            m2_q <= reg_req.wdata[5:0];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence held_s(c);
        c [*4];
    endsequence

    reset_idle_a: assert property (disable iff (1'b0)
        srst |=> irq_out_n && !reg_rsp.rvalid)
        else $error("pin or answer active after reset");
    mask_one_rd_a: assert property (
        reg_rsp.rvalid && $past(reg_req.addr) == PIM_ADDR_MASK_ONE
        |-> reg_rsp.rdata == {2'h0, $past(m1_q)})
        else $error("first mask read value wrong");
    mask_sw_rd_a: assert property (
        reg_rsp.rvalid && $past(reg_req.addr) == PIM_ADDR_SW_MASK
        |-> reg_rsp.rdata == {2'h0, $past(m2_q)})
        else $error("switch mask read value wrong");
    all_masked_a: assert property (
        held_s(m1_q == 6'h3F && m2_q == 6'h3F) |-> irq_out_n)
        else $error("pin low with every event masked");
    fault_low_a: assert property (
        held_s(sw_cond.overtemp[3] && !m2_q[PIM_BIT_SW3_FAULT])
        |-> !irq_out_n)
        else $error("unmasked switch fault left pin high");
    limit_low_a: assert property (
        held_s(sw_cond.limit_active[1] && sw_cond.enabled[1]
        && !m2_q[PIM_BIT_SW1_LIMIT]) |-> !irq_out_n)
        else $error("unmasked current limit left pin high");
    mains_change_a: assert property (
        $changed(evt_src.mains_detect_in) && !m1_q[PIM_BIT_MAINS]
        && !$past(srst) |-> ##[1:3] !irq_out_n)
        else $error("mains change did not pull pin low");
    button_change_a: assert property (
        $changed(evt_src.button_in) && !m1_q[PIM_BIT_BUTTON]
        && !$past(srst) |-> ##[1:3] !irq_out_n)
        else $error("button change did not pull pin low");
endmodule : pim_mask_logic_monitor

bind pim_mask_logic pim_mask_logic_monitor mon (.sys_clk(sys_clk),
    .srst(srst), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .sw_cond(sw_cond), .evt_src(evt_src), .irq_out_n(irq_out_n));
`default_nettype wire

// File: testbench/pim_host_model.sv
// host model: strobe register port master
`timescale 1ns/1ns
`default_nettype none
module pim_host_model
    import pim_pkg::*;
(
    // clock
    input  wire logic         sys_clk,
    // register port
    output var pim_reg_req_s  reg_req,
    input  wire pim_reg_rsp_s reg_rsp
);
    initial reg_req = '{rd: 1'b0, wr: 1'b0, addr: 8'hA5, wdata: 8'h5A};

    // one strobe cycle; released lines show inverted values
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
        @(negedge sys_clk);
        reg_req = '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge sys_clk);
        q = reg_rsp.rvalid ? reg_rsp.rdata : 8'hXX;
        reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : xfer
endmodule : pim_host_model
`default_nettype wire

// File: testbench/pim_mask_logic_tb.sv
// self-checking bench of the interrupt status and mask block
`timescale 1ns/1ns
`default_nettype none
module pim_mask_logic_tb
    import pim_pkg::*;
;
    logic         sys_clk = 1'b0;
    logic         srst = 1'b1;
    pim_reg_req_s reg_req;
    pim_reg_rsp_s reg_rsp;
    pim_sw_cond_s sw_cond = '0;
    pim_evt_src_s evt_src = '0;
    logic         irq_out_n;
    int           num_errors = 0;
    int           cmp_count = 0;
    int           seed = 8966;
    logic [7:0]   q;
    logic [7:0]   m;
    logic [7:0]   e;

    pim_mask_logic uut (.sys_clk(sys_clk), .srst(srst), .reg_req(reg_req),
        .reg_rsp(reg_rsp), .sw_cond(sw_cond), .evt_src(evt_src),
        .irq_out_n(irq_out_n));
    pim_host_model host (.sys_clk(sys_clk), .reg_req(reg_req),
        .reg_rsp(reg_rsp));

    initial forever #5 sys_clk = ~sys_clk;

    function automatic logic [7:0] sw_exp(input pim_sw_cond_s c);
        return {2'h0, c.overtemp[3], c.overtemp[2] | c.sw2_undervolt,
            c.overtemp[1], c.limit_active & c.enabled};
    endfunction : sw_exp

    task automatic check(input string what, input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rd_chk(input string what, input logic [7:0] a, exp);
        host.xfer(1'b0, a, 8'h00, q);
        check(what, exp, q);
    endtask : rd_chk

    task automatic test_done;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (20) @(negedge sys_clk);
        srst = 1'b0;
        rd_chk("events", PIM_ADDR_EVENT_ONE, 8'h00);
        rd_chk("sw status", PIM_ADDR_SW_STATUS, 8'h00);
        rd_chk("mask one", PIM_ADDR_MASK_ONE, 8'h00);
        rd_chk("sw mask", PIM_ADDR_SW_MASK, 8'h00);
        rd_chk("unmapped", 8'h05, 8'h00);
        check("irq", 8'h01, {7'h0, irq_out_n});
        for (int i = 0; i < 8; i++) begin
            m = (i == 0) ? 8'hFF : 8'($random(seed));
            host.xfer(1'b1, PIM_ADDR_MASK_ONE, m, q);
            rd_chk("mask one", PIM_ADDR_MASK_ONE, m & 8'h3F);
            host.xfer(1'b1, PIM_ADDR_SW_MASK, ~m, q);
            rd_chk("sw mask", PIM_ADDR_SW_MASK, ~m & 8'h3F);
            host.xfer(1'b1, PIM_ADDR_SW_STATUS, m, q);
            rd_chk("sw status ro", PIM_ADDR_SW_STATUS, 8'h00);
        end
        host.xfer(1'b1, PIM_ADDR_MASK_ONE, 8'h3F, q);
        // corner cases first: limit without enable, everything at once
        for (int i = 0; i < 40; i++) begin
            sw_cond = (i == 0) ? 10'h038 : (i == 1) ? 10'h3FF
                : 10'($random(seed));
            m = (i < 2) ? 8'h3F : 8'($random(seed));
            host.xfer(1'b1, PIM_ADDR_SW_MASK, m, q);
            repeat (3) @(negedge sys_clk);
            e = sw_exp(sw_cond);
            rd_chk("sw status", PIM_ADDR_SW_STATUS, e);
            e = {7'h0, ~|(e & ~m & 8'h3F)};
            check("irq", e, {7'h0, irq_out_n});
        end
        sw_cond = '0;
        repeat (3) @(negedge sys_clk);
        check("irq release", 8'h01, {7'h0, irq_out_n});
        host.xfer(1'b1, PIM_ADDR_SW_MASK, 8'h3F, q);
        // first six unmask one event each, last six keep all masked
        for (int i = 0; i < 12; i++) begin
            m = 8'h3F ^ ((i < 6) ? 8'h01 << i : 8'h00);
            host.xfer(1'b1, PIM_ADDR_MASK_ONE, m, q);
            host.xfer(1'b0, PIM_ADDR_EVENT_ONE, 8'h00, q);
            @(negedge sys_clk);
            evt_src = evt_src ^ (6'h01 << (i % 6));
            @(negedge sys_clk);
            evt_src = evt_src & 6'h18;
            repeat (2) @(negedge sys_clk);
            check("irq", {7'h0, i >= 6}, {7'h0, irq_out_n});
            rd_chk("events", PIM_ADDR_EVENT_ONE, 8'h01 << (i % 6));
            repeat (2) @(negedge sys_clk);
            check("irq release", 8'h01, {7'h0, irq_out_n});
        end
        // reset in mid-run while both masks are all ones
        srst = 1'b1;
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        rd_chk("mask one rst", PIM_ADDR_MASK_ONE, 8'h00);
        rd_chk("sw mask rst", PIM_ADDR_SW_MASK, 8'h00);
        check("irq rst", 8'h01, {7'h0, irq_out_n});
        test_done();
    end

    // generous bound over the expected run length
    initial begin
        #50000;
        num_errors++;
        test_done();
    end
endmodule : pim_mask_logic_tb
`default_nettype wire
